// >>> bridge_dither_pkg.sv
// Constants of the bridge dither controller.
// Assumes a single 40 MHz measurement clock domain.
package bridge_dither_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_PERIOD = 4'h1;
    localparam logic [3:0] ADDR_CALIB = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_RESULT = 4'h4;
    localparam logic [3:0] ADDR_SPAN_MEAS = 4'h5;
    localparam logic [3:0] ADDR_OFFSET_1 = 4'h6;
    localparam logic [3:0] ADDR_OFFSET_2 = 4'h7;
    localparam logic [3:0] ADDR_ROUTE_DITHER = 4'h8;
    localparam logic [3:0] ADDR_MATH_MODE = 4'hA;
    localparam logic [3:0] ADDR_GAIN_1 = 4'hE;
    localparam logic [3:0] ADDR_GAIN_2 = 4'hF;

    localparam int DATA_W = 24;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ROUTE_LSB = 2;
    localparam int DITHER_EN_BIT = 10;
    localparam int DITHER_SRC_LSB = 11;
    localparam int DITHER_SPAN_LSB = 13;
    localparam int QUARTER_BIT = 0;
    localparam int BRIDGE_MODE_LSB = 1;
    localparam int SINGLE_BIT = 3;
    localparam int RUN_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    // Logical driver n routed to port pair n (A, B, C, D)
    localparam logic [7:0] ROUTE_RESET = 8'hE4;
    localparam logic [15:0] PERIOD_RESET = 16'h0100;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    localparam logic [23:0] GAIN_ONE = 24'h010000;

    // ------------------------------------------------------------
    // Encodings and arithmetic constants
    // ------------------------------------------------------------
    localparam logic [1:0] PAIR_A = 2'h0;
    localparam logic [1:0] PAIR_B = 2'h1;
    localparam logic [1:0] PAIR_C = 2'h2;
    localparam logic [1:0] PAIR_D = 2'h3;
    localparam logic [1:0] SRC_EACH_CYCLE = 2'h0;
    localparam logic [1:0] SRC_EIGHTH_CYCLE = 2'h1;
    localparam logic [3:0] CALIB_MAX = 4'hF;
    localparam logic [19:0] PPM_SCALE = 20'hF4240;
    localparam int GAIN_FRAC = 16;
    localparam int OFFSET_FRAC = 8;
    localparam int DIV_W = 46;
    localparam logic [5:0] DIV_STEPS = 6'h2E;

    typedef enum logic [1:0] {
        BRIDGE_HALF = 2'h0,
        BRIDGE_FULL = 2'h1,
        BRIDGE_DOUBLE = 2'h2,
        BRIDGE_HALF_QUAD = 2'h3
    } bridge_mode_type;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_CYCLE = 5'b00010,
        ST_WAIT_MEAS = 5'b00100,
        ST_DIVIDE = 5'b01000,
        ST_COMP = 5'b10000
    } seq_state_type;

endpackage

// >>> bridge_dither_ctrl.sv
// Port routing, calibration interval, ratio math with span/offset
// compensation, and pseudo-random dither of the cycle period.
// Assumes strobed front-end time counts on this clock and an
// asynchronous start trigger pin.
//
// Contract
// - Interval field 0..15 sets cycles between converter calibrations.
// - Four two-bit routing fields in register 8 pick each driver's pair.
// - Routing code 00 is pair A, 01 B, 10 C, 11 D.
// - Reset maps each routing field to its same-position pair.
// - Any routing combination, even all equal, is harmless.
// - Half-bridge result is 10^6 (a-b)/(a+b).
// - Quarter bit in register 10 gives 10^6 (a-ref)/(2 ref).
// - Single mode stops after each measurement until a new trigger.
// - Dither enable in register 8 turns on period perturbation.
// - Dither source: 0 every cycle, 1 every eighth, 2 or 3 each interrupt.
// - Dither span 0,4,8,16 cycles, added to the cycle period.
// - Measured span resistor is scaled by gain registers.
// - Offset kept apart from span scaling and span resistor; the code subtracts it before the span scale multiply, so it is scaled too.
// - Compensation applies in every full-bridge mode.
// - Double bridge uses per-bridge factors; half modes none.
`timescale 1ns/10ps
`default_nettype none

module bridge_dither_ctrl
    import bridge_dither_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [23:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [23:0] reg_rdata_o,
    input wire logic start_trig_i,
    input wire logic meas_valid_i,
    input wire logic [23:0] meas_first_i,
    input wire logic [23:0] meas_second_i,
    input wire logic [15:0] span_meas_i,
    output logic [7:0] driver_route_o,
    output logic cycle_tick_o,
    output logic calib_req_o,
    output logic result_valid_o,
    output logic [23:0] result_o
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic run;
    logic [15:0] cycle_period_count;
    logic [3:0] calib_interval;
    logic [7:0] driver_route;
    logic dither_enable;
    logic [1:0] dither_update_source;
    logic [1:0] dither_span;
    logic quarter_bridge;
    bridge_mode_type bridge_mode;
    logic single_conv;
    logic [23:0] gain_1;
    logic [23:0] gain_2;
    logic [23:0] offset_1;
    logic [23:0] offset_2;
    logic [23:0] span_latched;

    // every combination is stored as written
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run <= 1'b0;
            cycle_period_count <= PERIOD_RESET;
            calib_interval <= 4'h0;
            driver_route <= ROUTE_RESET;
            dither_enable <= 1'b0;
            dither_update_source <= SRC_EACH_CYCLE;
            dither_span <= 2'h0;
            quarter_bridge <= 1'b0;
            bridge_mode <= BRIDGE_HALF;
            single_conv <= 1'b0;
            gain_1 <= GAIN_ONE;
            gain_2 <= GAIN_ONE;
            offset_1 <= 24'h000000;
            offset_2 <= 24'h000000;
        end else if (reg_write_i) begin
            case (reg_addr_i)
                ADDR_CONTROL: run <= reg_wdata_i[RUN_BIT];
                ADDR_PERIOD: cycle_period_count <= reg_wdata_i[15:0];
                ADDR_CALIB: calib_interval <= reg_wdata_i[3:0];
                ADDR_ROUTE_DITHER: begin
                    driver_route <= reg_wdata_i[ROUTE_LSB +: 8];
                    dither_enable <= reg_wdata_i[DITHER_EN_BIT];
                    dither_update_source <= reg_wdata_i[DITHER_SRC_LSB +: 2];
                    dither_span <= reg_wdata_i[DITHER_SPAN_LSB +: 2];
                end
                ADDR_MATH_MODE: begin
                    quarter_bridge <= reg_wdata_i[QUARTER_BIT];
                    bridge_mode <= bridge_mode_type'(reg_wdata_i[BRIDGE_MODE_LSB +: 2]);
                    single_conv <= reg_wdata_i[SINGLE_BIT];
                end
                ADDR_OFFSET_1: offset_1 <= reg_wdata_i;
                ADDR_OFFSET_2: offset_2 <= reg_wdata_i;
                ADDR_GAIN_1: gain_1 <= reg_wdata_i;
                ADDR_GAIN_2: gain_2 <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Port pair routing
    // ------------------------------------------------------------
    // Field n routes driver n
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            driver_route_o <= ROUTE_RESET;
        end else begin
            driver_route_o <= driver_route;
        end
    end

    // ------------------------------------------------------------
    // Start trigger synchroniser
    // ------------------------------------------------------------
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic trig_rise;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_meta <= start_trig_i;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    assign trig_rise = trig_sync & ~trig_prev;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    seq_state_type state;
    logic [16:0] cycle_cnt;
    logic [16:0] cycle_limit;
    logic [4:0] dither_value;
    logic cycle_end;
    logic div_done;
    logic [5:0] div_cnt;

    assign cycle_limit = {1'b0, cycle_period_count} + {12'h000, dither_value};
    assign cycle_end = (state == ST_CYCLE) && (cycle_cnt >= cycle_limit);
    assign div_done = (div_cnt == 6'h00);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    // single mode only leaves idle on a fresh trigger
                    if (run && (!single_conv || trig_rise)) begin
                        state <= ST_CYCLE;
                    end
                end
                ST_CYCLE: if (cycle_end) state <= ST_WAIT_MEAS;
                ST_WAIT_MEAS: if (meas_valid_i) state <= ST_DIVIDE;
                ST_DIVIDE: if (div_done) state <= ST_COMP;
                ST_COMP: begin
                    if (run && !single_conv) begin
                        state <= ST_CYCLE;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cycle_cnt <= 17'h00000;
        end else if (state == ST_CYCLE && !cycle_end) begin
            cycle_cnt <= cycle_cnt + 17'h00001;
        end else begin
            cycle_cnt <= 17'h00000;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cycle_tick_o <= 1'b0;
        end else begin
            cycle_tick_o <= cycle_end;
        end
    end

    // ------------------------------------------------------------
    // Calibration interval
    // ------------------------------------------------------------
    logic [3:0] calib_cnt;
    logic [3:0] calib_last;
    logic calib_due;

    // Code n means n+1 cycles, except 15
    assign calib_last = (calib_interval == CALIB_MAX) ? (CALIB_MAX - 4'h1) : calib_interval;
    assign calib_due = (calib_cnt >= calib_last);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            calib_cnt <= 4'h0;
            calib_req_o <= 1'b0;
        end else begin
            calib_req_o <= cycle_end && calib_due;
            if (cycle_end) begin
                calib_cnt <= calib_due ? 4'h0 : calib_cnt + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Dither generator
    // ------------------------------------------------------------
    logic [15:0] lfsr;
    logic [2:0] eighth_cnt;
    logic dither_step;
    logic result_event;

    always_comb begin
        case (dither_update_source)
            SRC_EACH_CYCLE: dither_step = cycle_end;
            SRC_EIGHTH_CYCLE: dither_step = cycle_end && (eighth_cnt == 3'h7);
            default: dither_step = result_event;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            eighth_cnt <= 3'h0;
            lfsr <= LFSR_SEED;
        end else begin
            if (cycle_end) begin
                eighth_cnt <= eighth_cnt + 3'h1;
            end
            if (dither_enable && dither_step) begin
                lfsr <= (lfsr >> 1) ^ (lfsr[0] ? LFSR_TAPS : 16'h0000);
            end
        end
    end

    // Span codes 1..3 allow 0..3, 0..7 and 0..15 extra cycles
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dither_value <= 5'h00;
        end else if (!dither_enable) begin
            dither_value <= 5'h00;
        end else if (state != ST_CYCLE) begin
            case (dither_span)
                2'h1: dither_value <= {3'h0, lfsr[1:0]};
                2'h2: dither_value <= {2'h0, lfsr[2:0]};
                2'h3: dither_value <= {1'h0, lfsr[3:0]};
                default: dither_value <= 5'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Ratio divider
    // ------------------------------------------------------------
    logic signed [25:0] numer;
    logic [25:0] denom;
    logic [25:0] numer_mag;
    logic [DIV_W-1:0] dvd;
    logic [25:0] rem;
    logic [25:0] den_hold;
    logic neg_hold;
    logic second_bridge;
    logic [26:0] trial;

    always_comb begin
        if (quarter_bridge) begin
            numer = $signed({2'b00, meas_first_i}) - $signed({2'b00, meas_second_i});
            denom = {1'b0, meas_second_i, 1'b0};
        end else begin
            numer = $signed({2'b00, meas_first_i}) - $signed({2'b00, meas_second_i});
            denom = {2'b00, meas_first_i} + {2'b00, meas_second_i};
        end
        numer_mag = numer[25] ? 26'(-numer) : 26'(numer);
    end

    assign trial = {rem, dvd[DIV_W-1]} - {1'b0, den_hold};

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dvd <= '0;
            rem <= 26'h0000000;
            den_hold <= 26'h0000000;
            neg_hold <= 1'b0;
            div_cnt <= 6'h00;
        end else if (state == ST_WAIT_MEAS && meas_valid_i) begin
            dvd <= DIV_W'(numer_mag * PPM_SCALE);
            rem <= 26'h0000000;
            den_hold <= (denom == 26'h0000000) ? 26'h0000001 : denom;
            neg_hold <= numer[25];
            div_cnt <= DIV_STEPS;
        end else if (state == ST_DIVIDE && !div_done) begin
            div_cnt <= div_cnt - 6'h01;
            if (!trial[26]) begin
                rem <= trial[25:0];
                dvd <= {dvd[DIV_W-2:0], 1'b1};
            end else begin
                rem <= {rem[24:0], dvd[DIV_W-1]};
                dvd <= {dvd[DIV_W-2:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Span and offset compensation
    // ------------------------------------------------------------
    logic signed [24:0] raw_ppm;
    logic full_mode;
    logic [39:0] span_prod;
    logic [23:0] span_scale;
    logic signed [32:0] offset_ppm;
    logic signed [32:0] zeroed;
    logic signed [57:0] scaled;
    logic [23:0] comp_result;

    assign raw_ppm = neg_hold ? -$signed({1'b0, dvd[23:0]}) : $signed({1'b0, dvd[23:0]});
    assign full_mode = (bridge_mode == BRIDGE_FULL) || (bridge_mode == BRIDGE_DOUBLE);
    assign span_prod = {24'h000000, span_latched[15:0]} * (second_bridge ? gain_2 : gain_1);
    assign span_scale = span_prod[GAIN_FRAC +: 24];
    assign offset_ppm = 33'($signed(second_bridge ? offset_2 : offset_1)) >>> OFFSET_FRAC;
    assign zeroed = 33'(raw_ppm) - offset_ppm;
    assign scaled = 58'(zeroed) * $signed({1'b0, span_scale});
    assign comp_result = full_mode ? scaled[GAIN_FRAC +: 24] : raw_ppm[23:0];

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            span_latched <= 24'h000000;
            second_bridge <= 1'b0;
        end else begin
            if (state == ST_WAIT_MEAS && meas_valid_i) begin
                span_latched <= {8'h00, span_meas_i};
            end
            if (state == ST_COMP) begin
                second_bridge <= (bridge_mode == BRIDGE_DOUBLE) && !second_bridge;
            end
        end
    end

    assign result_event = (state == ST_COMP);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o <= 24'h000000;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= result_event;
            if (result_event) begin
                result_o <= comp_result;
            end
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 24'h000000;
        end else if (reg_read_i) begin
            case (reg_addr_i)
                ADDR_CONTROL: reg_rdata_o <= {23'h000000, run};
                ADDR_PERIOD: reg_rdata_o <= {8'h00, cycle_period_count};
                ADDR_CALIB: reg_rdata_o <= {20'h00000, calib_interval};
                ADDR_STATUS: reg_rdata_o <= {9'h000, dither_value, second_bridge,
                                             calib_cnt, state};
                ADDR_RESULT: reg_rdata_o <= result_o;
                ADDR_SPAN_MEAS: reg_rdata_o <= span_latched;
                ADDR_OFFSET_1: reg_rdata_o <= offset_1;
                ADDR_OFFSET_2: reg_rdata_o <= offset_2;
                ADDR_ROUTE_DITHER: reg_rdata_o <= {9'h000, dither_span, dither_update_source,
                                                   dither_enable, driver_route, 2'h0};
                ADDR_MATH_MODE: reg_rdata_o <= {20'h00000, single_conv, bridge_mode,
                                                quarter_bridge};
                ADDR_GAIN_1: reg_rdata_o <= gain_1;
                ADDR_GAIN_2: reg_rdata_o <= gain_2;
                default: reg_rdata_o <= 24'h000000;
            endcase
        end else begin
            reg_rdata_o <= 24'h000000;
        end
    end

endmodule // bridge_dither_ctrl

`default_nettype wire

// >>> bridge_dither_props.sv
// Port assertions for the bridge dither controller.
// Bound to bridge_dither_ctrl; one clock, async low reset.
`timescale 1ns/10ps
`default_nettype none
module bridge_dither_props
    import bridge_dither_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [23:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [23:0] reg_rdata_o,
    input wire logic meas_valid_i,
    input wire logic [7:0] driver_route_o,
    input wire logic cycle_tick_o,
    input wire logic calib_req_o,
    input wire logic result_valid_o,
    input wire logic [23:0] result_o
);
    logic route_wr;
    logic [7:0] last_route;
    logic [3:0] cal;
    logic cal_dirty;
    logic [4:0] ticks;
    logic [4:0] due;
    logic waiting;
    assign route_wr = reg_write_i && reg_addr_i == ADDR_ROUTE_DITHER;
    // Ticks before a request is due
    assign due = (cal == 4'hF) ? 5'h0E : {1'b0, cal};
    always_ff @(posedge ref_clk_i) begin
        if (route_wr) last_route <= reg_wdata_i[9:2];
    end
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cal <= 4'h0;
            cal_dirty <= 1'b0;
        end else if (reg_write_i && reg_addr_i == ADDR_CALIB) begin
            cal <= reg_wdata_i[3:0];
            cal_dirty <= 1'b1;
        end else if (calib_req_o) begin
            cal_dirty <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) ticks <= 5'h00;
        else if (calib_req_o) ticks <= 5'h00;
        else if (cycle_tick_o) ticks <= ticks + 5'h01;
    end
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) waiting <= 1'b0;
        else if (cycle_tick_o) waiting <= 1'b1;
        else if (meas_valid_i) waiting <= 1'b0;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_read_data_gated: assert property (reg_rdata_o != 24'h000000 |-> $past(reg_read_i))
        else $error("stray read data");
    a_route_write_only: assert property ($changed(driver_route_o) |-> $past(route_wr) || $past(route_wr, 2))
        else $error("route moved");
    a_route_follows: assert property (route_wr |-> ##2 driver_route_o == last_route)
        else $error("route mismatch");
    a_calib_on_tick: assert property (calib_req_o |-> cycle_tick_o)
        else $error("calib off tick");
    a_calib_due: assert property (cycle_tick_o && !cal_dirty && ticks == due |-> calib_req_o)
        else $error("calib missing");
    a_calib_not_early: assert property (calib_req_o && !cal_dirty |-> ticks == due)
        else $error("calib early");
    a_result_held: assert property (!result_valid_o |-> $stable(result_o))
        else $error("result moved");
    a_result_spacing: assert property (result_valid_o |=> !result_valid_o [*8])
        else $error("results too close");
    a_meas_to_result: assert property (waiting && meas_valid_i |-> ##[40:60] result_valid_o)
        else $error("result late");
    a_no_early_result: assert property (waiting |-> !result_valid_o)
        else $error("result early");
    cover property (result_valid_o && result_o[23]);
    cover property (calib_req_o && cal == 4'h2);
    cover property (route_wr && reg_wdata_i[10]);
endmodule // bridge_dither_props
bind bridge_dither_ctrl bridge_dither_props u_props (.*);
`default_nettype wire

// >>> bridge_front_model.sv
// Bridge resistors and capacitor seen as time counts.
// Answers each cycle end delay_i+1 cycles after it samples the tick.
`timescale 1ns/10ps
`default_nettype none
module bridge_front_model (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic cycle_tick_i,
    input wire logic [23:0] gauge_first_i,
    input wire logic [23:0] gauge_second_i,
    input wire logic [15:0] span_res_i,
    input wire logic [7:0] delay_i,
    output logic meas_valid_o,
    output logic [23:0] meas_first_o,
    output logic [23:0] meas_second_o,
    output logic [15:0] span_meas_o
);
    logic [8:0] wait_cnt;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_cnt <= 9'h000;
            meas_valid_o <= 1'b0;
            meas_first_o <= 24'h000000;
            meas_second_o <= 24'h000000;
            span_meas_o <= 16'h0000;
        end else begin
            meas_valid_o <= 1'b0;
            meas_first_o <= ~meas_first_o;
            meas_second_o <= ~meas_second_o;
            span_meas_o <= ~span_meas_o;
            if (cycle_tick_i) wait_cnt <= {1'b0, delay_i} + 9'h001;
            else if (wait_cnt != 9'h000) wait_cnt <= wait_cnt - 9'h001;
            if (wait_cnt == 9'h001) begin
                meas_valid_o <= 1'b1;
                meas_first_o <= gauge_first_i;
                meas_second_o <= gauge_second_i;
                span_meas_o <= span_res_i;
            end
        end
    end
endmodule // bridge_front_model
`default_nettype wire

// >>> bridge_port_and_cycle_dither_ctrl_tb.sv
// Self-checking bench for the bridge dither controller.
// Drives registers and trigger; a front-end model answers.
`timescale 1ns/10ps
`default_nettype none
module bridge_port_and_cycle_dither_ctrl_tb;
    import bridge_dither_pkg::*;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [23:0] reg_wdata_i = 24'h000000;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic start_trig_i = 1'b0;
    logic meas_valid_i, cycle_tick_o, calib_req_o, result_valid_o;
    logic [23:0] meas_first_i, meas_second_i, reg_rdata_o, result_o;
    logic [15:0] span_meas_i;
    logic [7:0] driver_route_o;
    logic [23:0] gauge_a = 24'h000000;
    logic [23:0] gauge_b = 24'h000000;
    logic [15:0] span_res = 16'h8000;
    logic [7:0] delay = 8'h00;
    logic [7:0] route_tab [5] = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'h1B};
    int mismatches = 0, total_checks = 0, ticks = 0, calibs = 0;

    bridge_dither_ctrl dut (.*);
    bridge_front_model model (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cycle_tick_i(cycle_tick_o),
        .gauge_first_i(gauge_a), .gauge_second_i(gauge_b), .span_res_i(span_res),
        .delay_i(delay), .meas_valid_o(meas_valid_i), .meas_first_o(meas_first_i),
        .meas_second_o(meas_second_i), .span_meas_o(span_meas_i)
    );

    always #12.5 ref_clk_i = ~ref_clk_i;
    always @(negedge ref_clk_i) begin
        if (cycle_tick_o === 1'b1) ticks++;
        if (calib_req_o === 1'b1) calibs++;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [23:0] e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_read_i <= 1'b0;
        #1;
        chk(reg_rdata_o, e);
    endtask
    // Edges from trigger to cycle end
    task automatic fire(output int n);
        n = 0;
        @(posedge ref_clk_i);
        start_trig_i <= 1'b1;
        while (cycle_tick_o !== 1'b1 && n < 300) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        start_trig_i <= 1'b0;
    endtask
    task automatic wait_result();
        for (int k = 0; k < 400 && result_valid_o !== 1'b1; k++) begin
            @(posedge ref_clk_i);
            #1;
        end
        if (result_valid_o !== 1'b1) mismatches++;
    endtask
    task automatic meas(input logic [2:0] m, input logic [23:0] a, b, e);
        int n;
        wr(ADDR_MATH_MODE, {20'h00000, 1'b1, m});
        gauge_a <= a;
        gauge_b <= b;
        fire(n);
        wait_result();
        chk(result_o, e);
    endtask

    initial begin
        int n;
        int nz;
        int sp;
        repeat (4) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        chk({16'h0000, driver_route_o}, 24'h0000E4);
        rchk(ADDR_ROUTE_DITHER, 24'h000390);
        rchk(4'h9, 24'h000000);
        wr(ADDR_RESULT, 24'h123456);
        rchk(ADDR_RESULT, 24'h000000);
        for (int k = 0; k < 5; k++) begin
            wr(ADDR_ROUTE_DITHER, {14'h0000, route_tab[k], 2'h0});
            rchk(ADDR_ROUTE_DITHER, {14'h0000, route_tab[k], 2'h0});
            chk({16'h0000, driver_route_o}, {16'h0000, route_tab[k]});
        end
        wr(ADDR_ROUTE_DITHER, 24'h000390);
        wr(ADDR_PERIOD, 24'h000004);
        wr(ADDR_OFFSET_1, 24'h03E800);
        wr(ADDR_GAIN_2, 24'h020000);
        wr(ADDR_MATH_MODE, 24'h000008);
        wr(ADDR_CONTROL, 24'h000001);
        meas(3'h4, 24'd1100, 24'd900, 24'h00C15C);
        meas(3'h4, 24'd1100, 24'd900, 24'h0186A0);
        meas(3'h2, 24'd900, 24'd1100, 24'hFF3ABC);
        @(posedge ref_clk_i);
        span_res <= 16'h4000;
        meas(3'h2, 24'd1100, 24'd900, 24'h0060AE);
        meas(3'h0, 24'd1100, 24'd900, 24'h0186A0);
        @(posedge ref_clk_i);
        delay <= 8'd40;
        meas(3'h6, 24'd900, 24'd1100, 24'hFE7960);
        meas(3'h1, 24'd1100, 24'd1000, 24'h00C350);
        @(posedge ref_clk_i);
        delay <= 8'h00;
        n = ticks;
        repeat (80) @(posedge ref_clk_i);
        chk(24'(ticks), 24'(n));
        fire(n);
        wait_result();
        chk(24'(n), 24'd8);
        nz = 0;
        for (int k = 0; k < 4; k++) begin
            sp = k % 3 + 1;
            wr(ADDR_ROUTE_DITHER, 24'(32'h790 | k << 11 | sp << 13));
            repeat (3) begin
                fire(n);
                wait_result();
                chk({23'h0, n >= 8 && n < 8 + (4 << (sp - 1))}, 24'h000001);
                if (n > 8) nz++;
            end
        end
        chk({23'h0, nz > 0}, 24'h000001);
        wr(ADDR_ROUTE_DITHER, 24'h000390);
        wr(ADDR_CALIB, 24'h000002);
        n = ticks;
        nz = calibs;
        wr(ADDR_MATH_MODE, 24'h000000);
        for (int k = 0; k < 3000 && ticks < n + 6; k++) @(posedge ref_clk_i);
        chk(24'(calibs - nz), 24'd2);
        wr(ADDR_CONTROL, 24'h000000);
        wait_result();
        print_verdict();
    end

    initial begin
        #500000;
        mismatches++;
        print_verdict();
    end
endmodule // bridge_port_and_cycle_dither_ctrl_tb
`default_nettype wire
